//--- rtl/cfv_pkg.sv
// package: register map, field layout, codes and carriers of the CAN FIFO and vector status block
package cfv_pkg;

   // ----------------------------------------
   // register offsets (byte addresses)
   // ----------------------------------------
   localparam logic [7:0] ADDR_FILT_DEPTH = 8'h00;
   localparam logic [7:0] ADDR_EVT_CODE = 8'h04;
   localparam logic [7:0] ADDR_FIFO_SETUP = 8'h08;
   localparam logic [7:0] ADDR_FIFO_PTRS = 8'h0C;
   localparam logic [7:0] ADDR_IRQ_STAT = 8'h10;
   localparam logic [7:0] ADDR_IRQ_CLR = 8'h14;
   localparam logic [7:0] ADDR_IRQ_EN = 8'h18;
   localparam logic [7:0] ADDR_FIFO_RELEASE = 8'h1C;
   localparam logic [7:0] ADDR_HEAD_FILT = 8'h20;

   // ----------------------------------------
   // field positions
   // ----------------------------------------
   localparam int FILT_CNT_LSB = 0;
   localparam int FILT_HIT_LSB = 8;
   localparam int EVT_CODE_LSB = 0;
   localparam int POOL_SZ_LSB = 13;
   localparam int FIRST_BUF_LSB = 0;
   localparam int WR_PTR_LSB = 8;
   localparam int RD_PTR_LSB = 0;

   // ----------------------------------------
   // reset values and limits
   // ----------------------------------------
   localparam logic [4:0] FILT_CNT_RST = 5'h00;
   localparam logic [4:0] FILT_CNT_MAX = 5'h11;
   localparam logic [4:0] FILT_HIT_RST = 5'h00;
   localparam logic [2:0] POOL_SZ_RST = 3'h0;
   localparam logic [4:0] FIRST_BUF_RST = 5'h00;
   localparam logic [5:0] IRQ_EN_RST = 6'h00;
   localparam int PAYLOAD_BITS = 18;

   // ----------------------------------------
   // pending event codes
   // ----------------------------------------
   localparam logic [6:0] CODE_NONE = 7'h40;
   localparam logic [6:0] CODE_ERR = 7'h41;
   localparam logic [6:0] CODE_WAKE = 7'h42;
   localparam logic [6:0] CODE_OVF = 7'h43;
   localparam logic [6:0] CODE_AFULL = 7'h44;
   localparam logic [5:0] CODE_BUF_MAX = 6'h0F;

   // ----------------------------------------
   // interrupt status bit positions
   // ----------------------------------------
   localparam int IRQ_TX = 0;
   localparam int IRQ_RX = 1;
   localparam int IRQ_OVF = 2;
   localparam int IRQ_AFULL = 3;
   localparam int IRQ_ERR = 4;
   localparam int IRQ_WAKE = 5;

   // ----------------------------------------
   // carriers
   // ----------------------------------------
   typedef struct packed {
      logic wr;
      logic rd;
      logic [7:0] addr;
      logic [15:0] wdata;
   } cfv_bus_t;

   typedef struct packed {
      logic valid;
      logic [3:0] filt_idx;
      logic id_ok;
      logic [17:0] extended_identifier;
      logic [23:0] data;
   } cfv_acc_t;

   typedef struct packed {
      logic err;
      logic wake;
      logic rx_store;
      logic tx_done;
      logic [2:0] tx_buf;
   } cfv_evt_t;

endpackage

//--- rtl/cfv_mem.sv
// memory: filter index remembered for each buffer of the pool
`timescale 1ns/100ps
module cfv_mem (
   // clock and reset
   input wire logic core_clk_i,
   input wire logic rst_i,
   input wire logic ce_i,
   // write side
   input wire logic wr_i,
   input wire logic [4:0] wr_addr_i,
   input wire logic [4:0] wr_data_i,
   // read side
   input wire logic [4:0] rd_addr_i,
   output logic [4:0] rd_data_o
);

   logic [4:0] mem_reg [0:31];

   // array has no reset: its content is only meaningful once written
   always_ff @(posedge core_clk_i) begin
      if (ce_i && wr_i) begin
         mem_reg[wr_addr_i] <= wr_data_i;
      end
   end

   // registered read data
   always_ff @(posedge core_clk_i or posedge rst_i) begin
      if (rst_i) begin
         rd_data_o <= 5'h00;
      end else if (ce_i) begin
         rd_data_o <= mem_reg[rd_addr_i];
      end
   end

endmodule // cfv_mem

//--- rtl/cfv_top.sv
// top: payload filter depth, event code vector, buffer pool and receive FIFO pointers
//
// Local design decisions: the address map and the strobed register port.
`timescale 1ns/100ps
module cfv_top (
   // clock, reset, enable
   input wire logic core_clk_i,
   input wire logic rst_i,
   input wire logic ce_i,
   // register port
   input wire cfv_pkg::cfv_bus_t bus_i,
   output logic [15:0] rd_data_o,
   // acceptance check request and result
   input wire cfv_pkg::cfv_acc_t acc_i,
   output logic accept_o,
   output logic [4:0] hit_idx_o,
   // controller events and buffer target
   input wire cfv_pkg::cfv_evt_t evt_i,
   output logic [5:0] wr_buf_o,
   // interrupt
   output logic irq_o
);

   // ------------------------------------------------------------
   // functions
   // ------------------------------------------------------------

   // last buffer number of the pool for a size code
   function automatic logic [5:0] pool_last(input logic [2:0] sz);
      logic [5:0] last;
      case (sz)
         3'h0: last = 6'h03;
         3'h1: last = 6'h05;
         3'h2: last = 6'h07;
         3'h3: last = 6'h0B;
         3'h4: last = 6'h0F;
         3'h5: last = 6'h17;
         3'h6: last = 6'h1F;
         default: last = 6'h1F; // reserved code behaves as the largest pool
      endcase
      return last;
   endfunction

   // advance a FIFO pointer, wrapping to the area start
   function automatic logic [5:0] ptr_next(input logic [5:0] p, input logic [5:0] last,
                                           input logic [4:0] first);
      logic [5:0] n;
      if (p >= last) begin
         n = {1'b0, first};
      end else begin
         n = p + 6'h01;
      end
      return n;
   endfunction

   // payload compare: data bit i (byte 1 bit 7 downward) against identifier bit i
   function automatic logic payload_ok(input logic [4:0] cnt, input logic [17:0] extended_identifier,
                                       input logic [23:0] data);
      logic ok;
      ok = 1'b1;
      for (int i = 0; i < cfv_pkg::PAYLOAD_BITS; i++) begin
         // count 00000 selects no bit at all, count one only bit 0
         if ((i < int'(cnt)) || ((cnt == cfv_pkg::FILT_CNT_MAX) && (i == 17))) begin
            if (data[23-i] != extended_identifier[i]) begin
               ok = 1'b0;
            end
         end
      end
      return ok;
   endfunction

   // write strobe decode for one register
   function automatic logic wr_at(input cfv_pkg::cfv_bus_t b, input logic [7:0] a);
      return b.wr && (b.addr == a);
   endfunction

   // ------------------------------------------------------------
   // declarations
   // ------------------------------------------------------------
   logic [4:0] filt_cnt_reg;
   logic [4:0] filt_hit_reg;
   logic [2:0] pool_sz_reg;
   logic [4:0] first_buf_reg;
   logic [5:0] irq_en_reg;
   logic [5:0] irq_stat_reg;
   logic [5:0] irq_stat_next;
   logic [5:0] wp_reg;
   logic [5:0] rp_reg;
   logic [5:0] cnt_reg;
   logic [5:0] cnt_next;
   logic afull_reg;
   logic afull_next;
   logic [5:0] rx_buf_reg;
   logic [2:0] tx_buf_reg;
   logic [6:0] code_reg;
   logic [6:0] code_next;
   logic [15:0] rd_data_next;
   logic [4:0] head_filt;
   logic [5:0] last_buf;
   logic [5:0] area_len;
   logic setup_wr;
   logic fifo_full;
   logic store;
   logic overflow;
   logic pop;
   logic [5:0] irq_clr;
   logic [5:0] irq_set;
   logic [5:0] irq_act;

   // ------------------------------------------------------------
   // configuration registers
   // ------------------------------------------------------------

   // only the low five bits of the depth register exist
   always_ff @(posedge core_clk_i or posedge rst_i) begin
      if (rst_i) begin
         filt_cnt_reg <= cfv_pkg::FILT_CNT_RST;
      end else if (ce_i && wr_at(bus_i, cfv_pkg::ADDR_FILT_DEPTH)) begin
         filt_cnt_reg <= bus_i.wdata[cfv_pkg::FILT_CNT_LSB +: 5]; // values above 10001 are the writer's fault
      end
   end

   // pool size and area start; a write also restarts the FIFO
   always_ff @(posedge core_clk_i or posedge rst_i) begin
      if (rst_i) begin
         pool_sz_reg <= cfv_pkg::POOL_SZ_RST;
         first_buf_reg <= cfv_pkg::FIRST_BUF_RST;
      end else if (ce_i && setup_wr) begin
         pool_sz_reg <= bus_i.wdata[cfv_pkg::POOL_SZ_LSB +: 3];
         first_buf_reg <= bus_i.wdata[cfv_pkg::FIRST_BUF_LSB +: 5];
      end
   end

   // interrupt enable register
   always_ff @(posedge core_clk_i or posedge rst_i) begin
      if (rst_i) begin
         irq_en_reg <= cfv_pkg::IRQ_EN_RST;
      end else if (ce_i && wr_at(bus_i, cfv_pkg::ADDR_IRQ_EN)) begin
         irq_en_reg <= bus_i.wdata[5:0];
      end
   end

   // ------------------------------------------------------------
   // acceptance filtering
   // ------------------------------------------------------------

   // the identifier match comes from the filter bank; here only the payload part is added
   always_ff @(posedge core_clk_i or posedge rst_i) begin
      if (rst_i) begin
         accept_o <= 1'b0;
         filt_hit_reg <= cfv_pkg::FILT_HIT_RST;
      end else if (ce_i) begin
         accept_o <= acc_i.valid && acc_i.id_ok && payload_ok(filt_cnt_reg, acc_i.extended_identifier, acc_i.data);
         if (acc_i.valid && acc_i.id_ok && payload_ok(filt_cnt_reg, acc_i.extended_identifier, acc_i.data)) begin
            filt_hit_reg <= {1'b0, acc_i.filt_idx}; // four bit index keeps codes 10000 up unused
         end
      end
   end

   assign hit_idx_o = filt_hit_reg;

   // ------------------------------------------------------------
   // FIFO area bookkeeping
   // ------------------------------------------------------------
   assign setup_wr = wr_at(bus_i, cfv_pkg::ADDR_FIFO_SETUP);
   assign last_buf = pool_last(pool_sz_reg);

   // an area start past the pool end leaves an empty area: every store overflows
   always_comb begin
      if (last_buf >= {1'b0, first_buf_reg}) begin
         area_len = 6'(last_buf - {1'b0, first_buf_reg} + 6'h01);
      end else begin
         area_len = 6'h00;
      end
   end

   assign fifo_full = (cnt_reg >= area_len);
   assign store = evt_i.rx_store && !fifo_full;
   assign overflow = evt_i.rx_store && fifo_full;
   assign pop = wr_at(bus_i, cfv_pkg::ADDR_FIFO_RELEASE) && (cnt_reg != 6'h00);

   // fill level; a store and a release in one cycle cancel
   always_comb begin
      cnt_next = cnt_reg;
      if (store && !pop) begin
         cnt_next = cnt_reg + 6'h01;
      end else if (pop && !store) begin
         cnt_next = cnt_reg - 6'h01;
      end
      afull_next = (area_len != 6'h00) && ((cnt_next + 6'h01) >= area_len);
   end

   // pointers and fill level; setup write wins since it redefines the area
   always_ff @(posedge core_clk_i or posedge rst_i) begin
      if (rst_i) begin
         wp_reg <= 6'h00;
         rp_reg <= 6'h00;
         cnt_reg <= 6'h00;
         afull_reg <= 1'b0;
      end else if (ce_i) begin
         if (setup_wr) begin
            wp_reg <= {1'b0, bus_i.wdata[cfv_pkg::FIRST_BUF_LSB +: 5]};
            rp_reg <= {1'b0, bus_i.wdata[cfv_pkg::FIRST_BUF_LSB +: 5]};
            cnt_reg <= 6'h00;
            afull_reg <= 1'b0;
         end else begin
            if (store) begin
               wp_reg <= ptr_next(wp_reg, last_buf, first_buf_reg);
            end
            if (pop) begin
               rp_reg <= ptr_next(rp_reg, last_buf, first_buf_reg);
            end
            cnt_reg <= cnt_next;
            afull_reg <= afull_next;
         end
      end
   end

   assign wr_buf_o = wp_reg;

   // filter number of each stored message, looked up at the read pointer
   cfv_mem u_mem (
      .core_clk_i(core_clk_i),
      .rst_i(rst_i),
      .ce_i(ce_i),
      .wr_i(store),
      .wr_addr_i(wp_reg[4:0]),
      .wr_data_i(filt_hit_reg),
      .rd_addr_i(rp_reg[4:0]),
      .rd_data_o(head_filt)
   );

   // ------------------------------------------------------------
   // interrupt status
   // ------------------------------------------------------------

   // buffer numbers of the latest receive and transmit events
   always_ff @(posedge core_clk_i or posedge rst_i) begin
      if (rst_i) begin
         rx_buf_reg <= 6'h00;
         tx_buf_reg <= 3'h0;
      end else if (ce_i) begin
         if (store) begin
            rx_buf_reg <= wp_reg;
         end
         if (evt_i.tx_done) begin
            tx_buf_reg <= evt_i.tx_buf;
         end
      end
   end

   // event sources and software clears
   always_comb begin
      irq_set = 6'h00;
      irq_set[cfv_pkg::IRQ_TX] = evt_i.tx_done;
      irq_set[cfv_pkg::IRQ_RX] = store;
      irq_set[cfv_pkg::IRQ_OVF] = overflow;
      irq_set[cfv_pkg::IRQ_AFULL] = afull_next && !afull_reg && !setup_wr;
      irq_set[cfv_pkg::IRQ_ERR] = evt_i.err;
      irq_set[cfv_pkg::IRQ_WAKE] = evt_i.wake;
      irq_clr = wr_at(bus_i, cfv_pkg::ADDR_IRQ_CLR) ? bus_i.wdata[5:0] : 6'h00;
      // a set in the clearing cycle survives
      irq_stat_next = (irq_stat_reg & ~irq_clr) | irq_set;
   end

   always_ff @(posedge core_clk_i or posedge rst_i) begin
      if (rst_i) begin
         irq_stat_reg <= 6'h00;
      end else if (ce_i) begin
         irq_stat_reg <= irq_stat_next;
      end
   end

   assign irq_act = irq_stat_next & irq_en_reg;

   // ------------------------------------------------------------
   // pending event code
   // ------------------------------------------------------------

   // fixed priority: error, wake-up, overflow, almost full, receive, transmit
   always_comb begin
      code_next = cfv_pkg::CODE_NONE;
      if (irq_act[cfv_pkg::IRQ_ERR]) begin
         code_next = cfv_pkg::CODE_ERR;
      end else if (irq_act[cfv_pkg::IRQ_WAKE]) begin
         code_next = cfv_pkg::CODE_WAKE;
      end else if (irq_act[cfv_pkg::IRQ_OVF]) begin
         code_next = cfv_pkg::CODE_OVF;
      end else if (irq_act[cfv_pkg::IRQ_AFULL]) begin
         code_next = cfv_pkg::CODE_AFULL;
      end else if (irq_act[cfv_pkg::IRQ_RX] && (rx_buf_reg <= cfv_pkg::CODE_BUF_MAX)) begin
         code_next = {1'b0, rx_buf_reg}; // buffers past 15 have no code
      end else if (irq_act[cfv_pkg::IRQ_TX]) begin
         code_next = {4'h0, tx_buf_reg};
      end
   end

   // code and interrupt line are registered on the same edge as the status
   always_ff @(posedge core_clk_i or posedge rst_i) begin
      if (rst_i) begin
         code_reg <= cfv_pkg::CODE_NONE;
         irq_o <= 1'b0;
      end else if (ce_i) begin
         code_reg <= code_next;
         irq_o <= |irq_act;
      end
   end

   // ------------------------------------------------------------
   // register read
   // ------------------------------------------------------------

   // every field not placed below stays zero
   always_comb begin
      rd_data_next = 16'h0000;
      case (bus_i.addr)
         cfv_pkg::ADDR_FILT_DEPTH: begin
            rd_data_next[cfv_pkg::FILT_CNT_LSB +: 5] = filt_cnt_reg;
         end
         cfv_pkg::ADDR_EVT_CODE: begin
            rd_data_next[cfv_pkg::FILT_HIT_LSB +: 5] = filt_hit_reg;
            rd_data_next[cfv_pkg::EVT_CODE_LSB +: 7] = code_reg;
         end
         cfv_pkg::ADDR_FIFO_SETUP: begin
            rd_data_next[cfv_pkg::POOL_SZ_LSB +: 3] = pool_sz_reg;
            rd_data_next[cfv_pkg::FIRST_BUF_LSB +: 5] = first_buf_reg;
         end
         cfv_pkg::ADDR_FIFO_PTRS: begin
            rd_data_next[cfv_pkg::WR_PTR_LSB +: 6] = wp_reg;
            rd_data_next[cfv_pkg::RD_PTR_LSB +: 6] = rp_reg;
         end
         cfv_pkg::ADDR_IRQ_STAT: begin
            rd_data_next[5:0] = irq_stat_reg;
         end
         cfv_pkg::ADDR_IRQ_EN: begin
            rd_data_next[5:0] = irq_en_reg;
         end
         cfv_pkg::ADDR_HEAD_FILT: begin
            rd_data_next[4:0] = head_filt;
         end
         default: begin
            rd_data_next = 16'h0000; // write-only and unmapped words read zero
         end
      endcase
   end

   // read data stand only in the cycle after the strobe
   always_ff @(posedge core_clk_i or posedge rst_i) begin
      if (rst_i) begin
         rd_data_o <= 16'h0000;
      end else if (ce_i) begin
         rd_data_o <= bus_i.rd ? rd_data_next : 16'h0000;
      end
   end

endmodule // cfv_top

//--- sim/cfv_chk.sv
// checker: port-level assertions for the FIFO and event vector block
`timescale 1ns/100ps
module cfv_chk (
   // clock, reset, enable
   input wire logic core_clk_i,
   input wire logic rst_i,
   input wire logic ce_i,
   // observed ports
   input wire cfv_pkg::cfv_bus_t bus_i,
   input wire logic [15:0] rd_data_o,
   input wire cfv_pkg::cfv_acc_t acc_i,
   input wire logic accept_o,
   input wire logic [4:0] hit_idx_o,
   input wire cfv_pkg::cfv_evt_t evt_i,
   input wire logic [5:0] wr_buf_o,
   input wire logic irq_o
);
   // ----------------------------------------
   // assertions, all in the core clock domain
   // ----------------------------------------
   default clocking @(posedge core_clk_i); endclocking
   default disable iff (rst_i);

   rd_idle_a: assert property (ce_i && !bus_i.rd |=> rd_data_o == 16'h0000)
      else $error("read data not idle");
   depth_pad_a: assert property (ce_i && bus_i.rd && bus_i.addr == cfv_pkg::ADDR_FILT_DEPTH
      |=> rd_data_o[15:5] == 11'h000) else $error("depth upper bits set");
   hit_field_a: assert property (ce_i && bus_i.rd && bus_i.addr == cfv_pkg::ADDR_EVT_CODE
      |=> rd_data_o[15:13] == 3'h0 && rd_data_o[12:8] <= 5'h0F && !rd_data_o[7]) else $error("bad hit field");
   code_legal_a: assert property (ce_i && bus_i.rd && bus_i.addr == cfv_pkg::ADDR_EVT_CODE
      |=> rd_data_o[6:0] <= 7'h0F || (rd_data_o[6:0] >= 7'h40 && rd_data_o[6:0] <= 7'h44))
      else $error("reserved event code");
   ptr_read_a: assert property (ce_i && bus_i.rd && bus_i.addr == cfv_pkg::ADDR_FIFO_PTRS && !evt_i.rx_store
      |=> rd_data_o[15:13] == 3'h0 && rd_data_o[7:5] == 3'h0 && rd_data_o[13:8] == $past(wr_buf_o))
      else $error("pointer read mismatch");
   accept_gate_a: assert property (ce_i && !(acc_i.valid && acc_i.id_ok) |=> !accept_o)
      else $error("accept without request");
   hit_take_a: assert property (ce_i && acc_i.valid ##1 accept_o |-> hit_idx_o == {1'b0, $past(acc_i.filt_idx)})
      else $error("hit index not taken");
   hit_hold_a: assert property (ce_i && !acc_i.valid |=> $stable(hit_idx_o))
      else $error("hit index moved");
   wp_hold_a: assert property (ce_i && !evt_i.rx_store && !bus_i.wr |=> $stable(wr_buf_o))
      else $error("write pointer moved");
   wp_range_a: assert property (wr_buf_o[5] == 1'b0)
      else $error("write pointer out of range");
endmodule // cfv_chk

bind cfv_top cfv_chk i_chk (
   .core_clk_i(core_clk_i),
   .rst_i(rst_i),
   .ce_i(ce_i),
   .bus_i(bus_i),
   .rd_data_o(rd_data_o),
   .acc_i(acc_i),
   .accept_o(accept_o),
   .hit_idx_o(hit_idx_o),
   .evt_i(evt_i),
   .wr_buf_o(wr_buf_o),
   .irq_o(irq_o)
);

//--- sim/cfv_node_model.sv
// partner: other bus nodes, delivering acceptance checks and controller events
`timescale 1ns/100ps
module cfv_node_model (
   // clock
   input wire logic core_clk_i,
   // toward the block
   output cfv_pkg::cfv_acc_t acc_o,
   output cfv_pkg::cfv_evt_t evt_o
);
   // idle from time zero
   initial begin
      acc_o = '0;
      evt_o = '0;
   end

   // one message; released fields flip so stale data cannot look valid
   task automatic send_msg(input logic [3:0] idx, input logic ok, input logic [17:0] extended_identifier, input logic [23:0] dat);
      @(posedge core_clk_i);
      acc_o <= '{valid: 1'b1, filt_idx: idx, id_ok: ok, extended_identifier: extended_identifier, data: dat};
      @(posedge core_clk_i);
      acc_o <= '{valid: 1'b0, filt_idx: ~idx, id_ok: ~ok, extended_identifier: ~extended_identifier, data: ~dat};
   endtask

   // one-cycle event pulse
   task automatic fire(input cfv_pkg::cfv_evt_t e);
      @(posedge core_clk_i);
      evt_o <= e;
      @(posedge core_clk_i);
      evt_o <= {4'h0, ~e.tx_buf};
   endtask
endmodule // cfv_node_model

//--- sim/tb_top.sv
// testbench: register, acceptance, event code and FIFO pointer scenarios
`timescale 1ns/100ps
`define CHK(a, e) begin compares++; if ((a) !== (e)) begin n_mismatch++; \
   $display("[ERR] t=%0t got=%h exp=%h", $time, a, e); end end
module tb_top;
   // ----------------------------------------
   // stimulus and ports
   // ----------------------------------------
   logic core_clk_i = 1'b0;
   logic rst_i = 1'b1;
   logic ce_i = 1'b1;
   cfv_pkg::cfv_bus_t bus_i = '0;
   cfv_pkg::cfv_acc_t acc;
   cfv_pkg::cfv_evt_t evt;
   logic [15:0] rd_data_o;
   logic accept_o;
   logic [4:0] hit_idx_o;
   logic [5:0] wr_buf_o;
   logic irq_o;
   int n_mismatch = 0;
   int compares = 0;
   int sizes [7] = '{4, 6, 8, 12, 16, 24, 32};
   int cnt [6] = '{0, 1, 1, 16, 17, 17};
   int bad [6] = '{0, 0, 1, 16, 17, 31};
   logic [17:0] extended_identifier = 18'h2A5C3;
   logic [23:0] dat;
   logic [15:0] ptrs [3] = '{16'h0102, 16'h0103, 16'h0101};

   // free-running core clock
   always #20 core_clk_i = ~core_clk_i;

   cfv_top i_dut (
      .core_clk_i(core_clk_i),
      .rst_i(rst_i),
      .ce_i(ce_i),
      .bus_i(bus_i),
      .rd_data_o(rd_data_o),
      .acc_i(acc),
      .accept_o(accept_o),
      .hit_idx_o(hit_idx_o),
      .evt_i(evt),
      .wr_buf_o(wr_buf_o),
      .irq_o(irq_o)
   );

   cfv_node_model i_node (
      .core_clk_i(core_clk_i),
      .acc_o(acc),
      .evt_o(evt)
   );

   // ----------------------------------------
   // bus tasks and verdict
   // ----------------------------------------
   task automatic wr(input logic [7:0] a, input logic [15:0] v);
      @(posedge core_clk_i);
      bus_i <= '{wr: 1'b1, rd: 1'b0, addr: a, wdata: v};
      @(posedge core_clk_i);
      bus_i.wr <= 1'b0;
   endtask

   // data stand only in the cycle after the strobe, so sample mid-cycle
   task automatic rchk(input logic [7:0] a, input logic [15:0] e);
      @(posedge core_clk_i);
      bus_i <= '{wr: 1'b0, rd: 1'b1, addr: a, wdata: 16'h0000};
      @(posedge core_clk_i);
      bus_i.rd <= 1'b0;
      @(negedge core_clk_i);
      `CHK(rd_data_o, e)
   endtask

   task automatic print_verdict;
      if (n_mismatch == 0 && compares > 0)
         $display("[ PASS ]");
      else
         $display("[ FAIL ]");
      $finish;
   endtask

   // cuts a hang short; normal run is well under this
   initial begin
      repeat (20000) @(posedge core_clk_i);
      n_mismatch++;
      print_verdict;
   end

   // main sequence
   initial begin
      repeat (5) @(posedge core_clk_i);
      rst_i <= 1'b0;
      rchk(cfv_pkg::ADDR_FILT_DEPTH, 16'h0000);
      rchk(cfv_pkg::ADDR_EVT_CODE, 16'h0040);
      rchk(cfv_pkg::ADDR_FIFO_SETUP, 16'h0000);
      rchk(cfv_pkg::ADDR_FIFO_PTRS, 16'h0000);
      rchk(8'h24, 16'h0000);
      wr(cfv_pkg::ADDR_FILT_DEPTH, 16'hFFF1);
      rchk(cfv_pkg::ADDR_FILT_DEPTH, 16'h0011);
      wr(cfv_pkg::ADDR_EVT_CODE, 16'hFFFF);
      rchk(cfv_pkg::ADDR_EVT_CODE, 16'h0040);
      // payload compare depth: counts 0, 1, 16 and 17, each with one flipped bit or none
      for (int k = 0; k < 6; k++) begin
         wr(cfv_pkg::ADDR_FILT_DEPTH, 16'(cnt[k]));
         for (int i = 0; i < 18; i++) dat[23-i] = extended_identifier[i];
         dat[5:0] = 6'h00;
         if (bad[k] < 18) dat[23-bad[k]] = ~dat[23-bad[k]];
         i_node.send_msg(4'(k + 9), 1'b1, extended_identifier, dat);
         @(negedge core_clk_i);
         `CHK(accept_o, 1'(bad[k] >= ((cnt[k] > 16) ? 18 : cnt[k])))
         if (accept_o === 1'b1) `CHK(hit_idx_o, 5'(k + 9))
      end
      i_node.send_msg(4'h3, 1'b0, extended_identifier, dat);
      @(negedge core_clk_i);
      `CHK(accept_o, 1'b0)
      rchk(cfv_pkg::ADDR_EVT_CODE, 16'h0E40);
      // events: masked first (status only, code stays at none), then priority and clear
      i_node.fire(7'h40);
      rchk(cfv_pkg::ADDR_EVT_CODE, 16'h0E40);
      `CHK(irq_o, 1'b0)
      rchk(cfv_pkg::ADDR_IRQ_STAT, 16'h0010);
      wr(cfv_pkg::ADDR_IRQ_EN, 16'h003F);
      repeat (2) @(negedge core_clk_i);
      `CHK(irq_o, 1'b1)
      rchk(cfv_pkg::ADDR_IRQ_EN, 16'h003F);
      i_node.fire(7'h20);
      rchk(cfv_pkg::ADDR_EVT_CODE, 16'h0E41);
      wr(cfv_pkg::ADDR_IRQ_CLR, 16'h0010);
      rchk(cfv_pkg::ADDR_EVT_CODE, 16'h0E42);
      wr(cfv_pkg::ADDR_IRQ_CLR, 16'h003F);
      i_node.fire(7'h0F);
      rchk(cfv_pkg::ADDR_EVT_CODE, 16'h0E07);
      wr(cfv_pkg::ADDR_IRQ_CLR, 16'h003F);
      rchk(cfv_pkg::ADDR_EVT_CODE, 16'h0E40);
      // FIFO area 1..3 of a four-buffer pool: fill, wrap, overflow, drain
      wr(cfv_pkg::ADDR_FIFO_SETUP, 16'h0001);
      rchk(cfv_pkg::ADDR_FIFO_PTRS, 16'h0101);
      for (int k = 0; k < 3; k++) begin
         i_node.fire(7'h10);
         @(negedge core_clk_i);
         `CHK(wr_buf_o, ptrs[k][5:0])
      end
      rchk(cfv_pkg::ADDR_EVT_CODE, 16'h0E44);
      i_node.fire(7'h10);
      rchk(cfv_pkg::ADDR_EVT_CODE, 16'h0E43);
      rchk(cfv_pkg::ADDR_FIFO_PTRS, 16'h0101);
      rchk(cfv_pkg::ADDR_HEAD_FILT, 16'h000E);
      for (int k = 0; k < 3; k++) begin
         wr(cfv_pkg::ADDR_FIFO_RELEASE, 16'h0001);
         rchk(cfv_pkg::ADDR_FIFO_PTRS, {8'h01, ptrs[k][7:0]});
      end
      wr(cfv_pkg::ADDR_IRQ_CLR, 16'h003F);
      i_node.fire(7'h10);
      rchk(cfv_pkg::ADDR_EVT_CODE, 16'h0E01);
      // every pool size: two-buffer area at the top, must wrap
      for (int s = 0; s < 7; s++) begin
         wr(cfv_pkg::ADDR_FIFO_SETUP, {3'(s), 13'(sizes[s] - 2)});
         rchk(cfv_pkg::ADDR_FIFO_SETUP, {3'(s), 13'(sizes[s] - 2)});
         i_node.fire(7'h10);
         @(negedge core_clk_i);
         `CHK(wr_buf_o, 6'(sizes[s] - 1))
         i_node.fire(7'h10);
         @(negedge core_clk_i);
         `CHK(wr_buf_o, 6'(sizes[s] - 2))
      end
      // frozen enable: neither an event nor a setup write may land
      @(posedge core_clk_i);
      ce_i <= 1'b0;
      i_node.fire(7'h10);
      wr(cfv_pkg::ADDR_FIFO_SETUP, 16'h0000);
      @(negedge core_clk_i);
      `CHK(wr_buf_o, 6'h1E)
      @(posedge core_clk_i);
      ce_i <= 1'b1;
      rchk(cfv_pkg::ADDR_FIFO_SETUP, 16'hC01E);
      // reset in mid-run brings setup, event code, irq_o and wr_buf_o back to their idle values
      @(posedge core_clk_i);
      rst_i <= 1'b1;
      repeat (2) @(posedge core_clk_i);
      rst_i <= 1'b0;
      rchk(cfv_pkg::ADDR_FIFO_SETUP, 16'h0000);
      rchk(cfv_pkg::ADDR_EVT_CODE, 16'h0040);
      `CHK(irq_o, 1'b0)
      `CHK(wr_buf_o, 6'h00)
      print_verdict;
   end
endmodule // tb_top
